// >>> dv/asr_sram_model.sv
// Behavioural model of the asynchronous byte memory
`timescale 1ns/1ns
`default_nettype none

module asr_sram_model
(
   // Memory pins
   input wire logic [18:0] addr_i,
   input wire logic cs_n_i,
   input wire logic we_n_i,
   input wire logic oe_n_i,
   input wire logic [7:0] dq_i,
   output logic [7:0] dq_o,
   output logic dq_oe_o,
   // Model control
   input wire logic slow_i
);
   logic [7:0] mem [logic [18:0]];
   logic [7:0] rd_val = 8'h00;
   logic [7:0] last_q = 8'h00;
   logic rd_en, wr_en, vld, vld_f, vld_s;

   assign rd_en = !cs_n_i && we_n_i && !oe_n_i;
   assign wr_en = !cs_n_i && !we_n_i;
   assign #(10, 5) dq_oe_o = rd_en;
   assign #(25, 0) vld_f = rd_en;
   assign #(55, 0) vld_s = rd_en;
   assign vld = slow_i ? vld_s : vld_f;
   always @(addr_i or rd_en)
      if (rd_en)
         rd_val = mem.exists(addr_i) ? mem[addr_i] : addr_i[7:0] ^ 8'h5A;
   // Stale bus shows inverse of last data
   always @(negedge vld)
      last_q = rd_val;
   assign dq_o = vld ? rd_val : ~last_q;
   always @(negedge wr_en)
      if (!$isunknown(addr_i))
         mem[addr_i] = dq_i;
endmodule

`default_nettype wire

// >>> dv/async_sram_byte_port_test.sv
// Self-checking bench for the asynchronous byte memory host controller
`timescale 1ns/1ns
`default_nettype none

module async_sram_byte_port_test;
   logic clk_i = 1'b0;
   logic reset_n_i = 1'b0;
   logic ce_i = 1'b1;
   logic req_valid_i = 1'b0;
   logic req_write_i = 1'b0;
   logic [18:0] req_addr_i = 19'h00000;
   logic [7:0] req_wdata_i = 8'h00;
   logic req_ready_o, rsp_valid_o, mem_cs_n_o, mem_we_n_o, mem_oe_n_o;
   logic mem_dq_oe_o, sram_oe, prev_wr, prev_cs;
   logic slow = 1'b0;
   logic ce_rand = 1'b0;
   logic [7:0] rsp_rdata_o, mem_dq_o, mem_dq_i, sram_dq, prev_dq;
   logic [18:0] mem_addr_o, prev_addr;
   logic [7:0] ref_mem [logic [18:0]];
   int bad_count = 0;
   int n_checks = 0;
   int seed = 3278;
   int low_cnt = 0;
   int dq_cnt = 0;

   always #2 clk_i = ~clk_i;
   assign mem_dq_i = mem_dq_oe_o ? mem_dq_o : sram_dq;

   asr_host_ctrl asr_host_ctrl_inst (.clk_i(clk_i), .reset_n_i(reset_n_i),
      .ce_i(ce_i), .req_valid_i(req_valid_i), .req_write_i(req_write_i),
      .req_addr_i(req_addr_i), .req_wdata_i(req_wdata_i),
      .req_ready_o(req_ready_o), .rsp_valid_o(rsp_valid_o),
      .rsp_rdata_o(rsp_rdata_o), .mem_addr_o(mem_addr_o),
      .mem_cs_n_o(mem_cs_n_o), .mem_we_n_o(mem_we_n_o),
      .mem_oe_n_o(mem_oe_n_o), .mem_dq_o(mem_dq_o),
      .mem_dq_oe_o(mem_dq_oe_o), .mem_dq_i(mem_dq_i));

   asr_sram_model asr_sram_model_inst (.addr_i(mem_addr_o),
      .cs_n_i(mem_cs_n_o), .we_n_i(mem_we_n_o), .oe_n_i(mem_oe_n_o),
      .dq_i(mem_dq_i), .dq_o(sram_dq), .dq_oe_o(sram_oe), .slow_i(slow));

   // -----------------------------------------------------------
   // Tasks and functions
   // -----------------------------------------------------------
   function automatic logic [7:0] exp_rd(input logic [18:0] a);
      return ref_mem.exists(a) ? ref_mem[a] : a[7:0] ^ 8'h5A;
   endfunction

   task automatic check(input string what, input logic [31:0] seen,
                        input logic [31:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
      end
   endtask

   task automatic tick();
      @(posedge clk_i);
      #1;
      ce_i = !ce_rand || ($random(seed) % 4 != 0);
   endtask

   task automatic idle_chk();
      check("idle", 32'({req_ready_o, mem_cs_n_o, mem_we_n_o, mem_oe_n_o,
         mem_dq_oe_o, rsp_valid_o, rsp_rdata_o}), 32'h3C00);
   endtask

   task automatic op(input logic wr, input logic [18:0] a,
                     input logic [7:0] d, input logic poke);
      int n;
      int lat;
      logic c;
      n = 0;
      lat = 0;
      req_valid_i = 1'b1;
      req_write_i = wr;
      req_addr_i = a;
      req_wdata_i = d;
      while (!(req_ready_o === 1'b1 && ce_i) && n < 200)
      begin
         tick();
         n++;
      end
      tick();
      req_valid_i = poke;
      req_addr_i = a ^ 19'h00001;
      req_wdata_i = ~d;
      if (wr)
         ref_mem[a] = d;
      while ((wr ? req_ready_o : rsp_valid_o) !== 1'b1 && n < 400)
      begin
         c = ce_i;
         tick();
         lat += int'(c);
         n++;
         if (lat == 3)
            req_valid_i = 1'b0;
      end
      req_valid_i = 1'b0;
      check(wr ? "wr_cycle" : "rd_cycle", 32'(lat), 32'd14);
      if (!wr)
         check("rdata", 32'(rsp_rdata_o), 32'(exp_rd(a)));
   endtask

   task automatic results();
      $display("checks %0d errors %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   // -----------------------------------------------------------
   // Pin monitor
   // -----------------------------------------------------------
   always @(negedge clk_i)
   begin
      if (reset_n_i)
      begin
         if (sram_oe)
            check("contention", 32'(mem_dq_oe_o), 32'h0);
         if (!mem_cs_n_o && !mem_oe_n_o)
            check("we_in_read", 32'(mem_we_n_o), 32'h1);
         if (!prev_cs && !mem_cs_n_o)
            check("addr_hold", 32'(mem_addr_o), 32'(prev_addr));
         if (prev_wr && (mem_cs_n_o || mem_we_n_o))
         begin
            check("we_width", 32'(low_cnt >= 10), 32'h1);
            check("dq_setup", 32'(dq_cnt >= 7), 32'h1);
            check("dq_hold", 32'({mem_dq_oe_o, mem_dq_o}),
               32'({1'b1, prev_dq}));
         end
      end
      low_cnt = (!mem_cs_n_o && !mem_we_n_o) ? low_cnt + 1 : 0;
      dq_cnt = (mem_dq_oe_o && mem_dq_o === prev_dq) ? dq_cnt + 1 : 0;
      prev_wr = !mem_cs_n_o && !mem_we_n_o;
      prev_cs = mem_cs_n_o;
      prev_addr = mem_addr_o;
      prev_dq = mem_dq_o;
   end

   // -----------------------------------------------------------
   // Main sequence
   // -----------------------------------------------------------
   initial
   begin
      repeat (6) @(posedge clk_i);
      #1;
      reset_n_i = 1'b1;
      idle_chk();
      op(1'b1, 19'h00000, 8'hA5, 1'b0);
      op(1'b1, 19'h7FFFF, 8'h3C, 1'b1);
      op(0, 19'h7FFFF, 8'h00, 1'b0);
      op(0, 19'h7FFFE, 8'h00, 1'b0);
      op(0, 19'h00000, 8'h00, 1'b0);
      op(1'b1, 19'h00000, 8'h5B, 1'b0);
      op(0, 19'h00000, 8'h00, 1'b0);
      for (int i = 0; i < 60; i++)
      begin
         ce_rand = (i >= 30);
         slow = 1'($random(seed));
         op(1'($random(seed)), {15'h0000, 4'($random(seed))},
            8'($random(seed)), 1'b0);
      end
      ce_rand = 1'b0;
      req_write_i = 1'b1;
      req_addr_i = 19'h40000;
      req_valid_i = 1'b1;
      for (int n = 0; n < 40 && req_ready_o !== 1'b1; n++)
         tick();
      repeat (6) tick();
      reset_n_i = 1'b0;
      req_valid_i = 1'b0;
      repeat (2) tick();
      idle_chk();
      reset_n_i = 1'b1;
      op(1'b1, 19'h40001, 8'hC3, 1'b0);
      op(0, 19'h40001, 8'h00, 1'b0);
      results();
   end

   initial
   begin
      #100000;
      bad_count++;
      results();
   end
endmodule

`default_nettype wire

// >>> hdl/asr_delay_cnt.sv
// Down counter that times each phase of a memory cycle
`timescale 1ns/1ns
`default_nettype none

module asr_delay_cnt
#(
   parameter int CNT_W = 5
)
(
   // Clock, reset and enable
   input wire logic clk_i,
   input wire logic reset_n_i,
   input wire logic ce_i,
   // Control
   input wire logic load_i,
   input wire logic [CNT_W-1:0] load_val_i,
   // Status
   output logic done_o
);

   typedef struct packed {
      logic [CNT_W-1:0] cnt;
   } asr_cnt_state_t;

   asr_cnt_state_t state_ff;
   asr_cnt_state_t nxt_state;

   if (CNT_W < 1)
   begin : g_chk
      $error("asr_delay_cnt: CNT_W must be at least 1");
   end

   always_comb
   begin
      nxt_state = state_ff;
      if (load_i)
      begin
         nxt_state.cnt = load_val_i;
      end
      else if (state_ff.cnt != '0)
      begin
         nxt_state.cnt = state_ff.cnt - CNT_W'(1);
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (!reset_n_i)
      begin
         state_ff <= '0;
      end
      else if (ce_i)
      begin
         state_ff <= nxt_state;
      end
   end

   assign done_o = (state_ff.cnt == '0);

endmodule

`default_nettype wire

// >>> hdl/asr_host_ctrl.sv
// Host controller driving an asynchronous 512K x 8 static memory
`timescale 1ns/1ns
`default_nettype none
`include "asr_params.svh"

module asr_host_ctrl
#(
   parameter int ADDR_W = `ASR_ADDR_W,
   parameter int DATA_W = `ASR_DATA_W,
   parameter int CNT_W = `ASR_CNT_W
)
(
   // Clock, reset, enable
   input wire logic clk_i,
   input wire logic reset_n_i,
   input wire logic ce_i,
   // Request side
   input wire logic req_valid_i,
   input wire logic req_write_i,
   input wire logic [ADDR_W-1:0] req_addr_i,
   input wire logic [DATA_W-1:0] req_wdata_i,
   output logic req_ready_o,
   // Response side
   output logic rsp_valid_o,
   output logic [DATA_W-1:0] rsp_rdata_o,
   // Memory pins
   output logic [ADDR_W-1:0] mem_addr_o,
   output logic mem_cs_n_o,
   output logic mem_we_n_o,
   output logic mem_oe_n_o,
   output logic [DATA_W-1:0] mem_dq_o,
   output logic mem_dq_oe_o,
   input wire logic [DATA_W-1:0] mem_dq_i
);

   localparam int RD_CYC = `ASR_RD_CYC;
   localparam int HZ_CYC = `ASR_HZ_CYC;
   localparam int SD_CYC = `ASR_SD_CYC;
   localparam int WE_CYC = `ASR_WE_CYC;
   localparam int WC_CYC = `ASR_WC_CYC;
   localparam int WA_CYC = `ASR_WR_ADDR_CYC;
   localparam int WH_CYC = `ASR_WR_HOLD_CYC;

   // -----------------------------------------------------------
   // Parameter checks
   // -----------------------------------------------------------
   if (ADDR_W < 1 || DATA_W < 1 || RD_CYC > (1 << CNT_W) ||
       WE_CYC > (1 << CNT_W) || HZ_CYC > (1 << CNT_W) ||
       WA_CYC + WE_CYC + WH_CYC < WC_CYC)
   begin : g_chk
      $error("asr_host_ctrl: parameters cannot meet memory timing");
   end

   typedef struct packed {
      asr_pkg::asr_state_t st;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic [DATA_W-1:0] rdata;
      logic cs_n;
      logic we_n;
      logic oe_n;
      logic dq_oe;
      logic ready;
      logic rsp;
   } asr_host_state_t;

   asr_host_state_t state_ff;
   asr_host_state_t nxt_state;
   logic cnt_load;
   logic [CNT_W-1:0] cnt_val;
   logic cnt_done;

   // -----------------------------------------------------------
   // Phase timer
   // -----------------------------------------------------------
   asr_delay_cnt #(
      .CNT_W(CNT_W)
   ) u_cnt (
      .clk_i(clk_i),
      .reset_n_i(reset_n_i),
      .ce_i(ce_i),
      .load_i(cnt_load),
      .load_val_i(cnt_val),
      .done_o(cnt_done)
   );

   // -----------------------------------------------------------
   // Sequencer
   // -----------------------------------------------------------
   always_comb
   begin
      nxt_state = state_ff;
      nxt_state.rsp = 1'b0;
      cnt_load = 1'b0;
      cnt_val = '0;
      case (state_ff.st)
         asr_pkg::ST_IDLE:
         begin
            if (req_valid_i)
            begin
               nxt_state.addr = req_addr_i;
               nxt_state.wdata = req_wdata_i;
               nxt_state.ready = 1'b0;
               nxt_state.cs_n = 1'b0;
               cnt_load = 1'b1;
               if (req_write_i)
               begin
                  nxt_state.oe_n = 1'b1;
                  nxt_state.st = asr_pkg::ST_WR_ADDR;
                  cnt_val = CNT_W'(WA_CYC - 1);
               end
               else
               begin
                  nxt_state.oe_n = 1'b0;
                  nxt_state.st = asr_pkg::ST_RD_ACC;
                  cnt_val = CNT_W'(RD_CYC - 1);
               end
            end
         end
         asr_pkg::ST_RD_ACC:
         begin
            if (cnt_done)
            begin
               nxt_state.rdata = mem_dq_i;
               nxt_state.rsp = 1'b1;
               nxt_state.cs_n = 1'b1;
               nxt_state.oe_n = 1'b1;
               nxt_state.st = asr_pkg::ST_RD_TURN;
               cnt_load = 1'b1;
               cnt_val = CNT_W'(HZ_CYC - 1);
            end
         end
         asr_pkg::ST_RD_TURN:
         begin
            if (cnt_done)
            begin
               nxt_state.ready = 1'b1;
               nxt_state.st = asr_pkg::ST_IDLE;
            end
         end
         asr_pkg::ST_WR_ADDR:
         begin
            if (cnt_done)
            begin
               nxt_state.we_n = 1'b0;
               nxt_state.dq_oe = 1'b1;
               nxt_state.st = asr_pkg::ST_WR_PULSE;
               cnt_load = 1'b1;
               cnt_val = CNT_W'(WE_CYC - 1);
            end
         end
         asr_pkg::ST_WR_PULSE:
         begin
            if (cnt_done)
            begin
               nxt_state.we_n = 1'b1;
               nxt_state.cs_n = 1'b1;
               nxt_state.st = asr_pkg::ST_WR_HOLD;
               cnt_load = 1'b1;
               cnt_val = CNT_W'(WH_CYC - 1);
            end
         end
         asr_pkg::ST_WR_HOLD:
         begin
            if (cnt_done)
            begin
               nxt_state.dq_oe = 1'b0;
               nxt_state.ready = 1'b1;
               nxt_state.st = asr_pkg::ST_IDLE;
            end
         end
         default:
         begin
            nxt_state.st = asr_pkg::ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_i)
   begin
      if (!reset_n_i)
      begin
         state_ff <= '0;
         state_ff.st <= asr_pkg::ST_IDLE;
         state_ff.cs_n <= 1'b1;
         state_ff.we_n <= 1'b1;
         state_ff.oe_n <= 1'b1;
         state_ff.ready <= 1'b1;
      end
      else if (ce_i)
      begin
         state_ff <= nxt_state;
      end
   end

   assign req_ready_o = state_ff.ready;
   assign rsp_valid_o = state_ff.rsp;
   assign rsp_rdata_o = state_ff.rdata;
   assign mem_addr_o = state_ff.addr;
   assign mem_cs_n_o = state_ff.cs_n;
   assign mem_we_n_o = state_ff.we_n;
   assign mem_oe_n_o = state_ff.oe_n;
   assign mem_dq_o = state_ff.wdata;
   assign mem_dq_oe_o = state_ff.dq_oe;

   // -----------------------------------------------------------
   // Assertion helpers
   // -----------------------------------------------------------
   logic [7:0] we_low_cnt;
   logic [7:0] rd_low_cnt;
   logic [7:0] float_cnt;
   logic [7:0] sd_cnt;

   always_ff @(posedge clk_i)
   begin
      if (!reset_n_i)
      begin
         we_low_cnt <= 8'h00;
         rd_low_cnt <= 8'h00;
         float_cnt <= 8'hFF;
         sd_cnt <= 8'h00;
      end
      else
      begin
         we_low_cnt <= mem_we_n_o ? 8'h00 : we_low_cnt + 8'h01;
         rd_low_cnt <= (mem_cs_n_o | mem_oe_n_o) ? 8'h00 :
            rd_low_cnt + 8'h01;
         float_cnt <= !mem_oe_n_o ? 8'h00 :
            (float_cnt == 8'hFF ? float_cnt : float_cnt + 8'h01);
         sd_cnt <= (mem_dq_oe_o & !mem_we_n_o) ? sd_cnt + 8'h01 : 8'h00;
      end
   end

   // -----------------------------------------------------------
   // Assertions
   // -----------------------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!reset_n_i);

   strobe_excl_a: assert property (
      !mem_we_n_o |-> mem_oe_n_o && !mem_cs_n_o)
      else $error("write strobe low with gate low or deselected");

   // host drive only with gate high
   bus_owner_a: assert property (
      mem_dq_oe_o |-> mem_oe_n_o)
      else $error("host drives bus while gate is low");

   turn_float_a: assert property (
      $rose(mem_dq_oe_o) |-> float_cnt >= 8'(HZ_CYC))
      else $error("host drives bus before memory floated");

   we_width_a: assert property (
      $rose(mem_we_n_o) |-> we_low_cnt >= 8'(WE_CYC))
      else $error("write strobe pulse too short");

   data_setup_a: assert property (
      $rose(mem_we_n_o) |-> $past(sd_cnt) >= 8'(SD_CYC))
      else $error("write data setup too short");

   data_hold_a: assert property (
      $rose(mem_we_n_o) |-> mem_dq_oe_o ##1 (mem_dq_oe_o || mem_we_n_o))
      else $error("write data released too early");

   wr_addr_a: assert property (
      !mem_we_n_o && $past(!mem_we_n_o) |-> $stable(mem_addr_o))
      else $error("address moved during write pulse");

   wr_start_a: assert property (
      $fell(mem_we_n_o) |-> $past(!mem_cs_n_o))
      else $error("write strobe fell before select");

   rd_access_a: assert property (
      $rose(rsp_valid_o) |-> $past(rd_low_cnt) >= 8'(RD_CYC - 1))
      else $error("read data taken before access time");

   rd_addr_a: assert property (
      !mem_oe_n_o && $past(!mem_oe_n_o) |-> $stable(mem_addr_o))
      else $error("address moved during read");

   wr_end_a: assert property (
      $rose(mem_we_n_o) |-> $rose(mem_cs_n_o))
      else $error("write strobe and select did not rise together");

   rd_done_c: cover property (rsp_valid_o);
   wr_done_c: cover property ($rose(mem_we_n_o));
   rd_after_wr_c: cover property (
      $rose(mem_we_n_o) ##[1:40] $fell(mem_oe_n_o));
   wr_after_rd_c: cover property (
      rsp_valid_o ##[1:40] $fell(mem_we_n_o));

endmodule

`default_nettype wire

// >>> hdl/asr_params.svh
// Constants for the asynchronous byte memory host controller
`ifndef ASR_PARAMS_SVH
`define ASR_PARAMS_SVH

// -----------------------------------------------------------
// Widths
// -----------------------------------------------------------
`define ASR_ADDR_W 19
`define ASR_DATA_W 8
`define ASR_CNT_W 5

// -----------------------------------------------------------
// Times in ns
// -----------------------------------------------------------
`define ASR_CLK_PERIOD_NS 4
`define ASR_T_RC_NS 55
`define ASR_T_AA_NS 55
`define ASR_T_HZ_NS 20
`define ASR_T_HZWE_NS 20
`define ASR_T_WC_NS 55
`define ASR_T_PWE_NS 40
`define ASR_T_SD_NS 25

// -----------------------------------------------------------
// Cycle counts, least times rounded up
// -----------------------------------------------------------
`define ASR_CEIL(ns) (((ns) + `ASR_CLK_PERIOD_NS - 1) / `ASR_CLK_PERIOD_NS)
`define ASR_MAX(a, b) (((a) > (b)) ? (a) : (b))
`define ASR_RD_CYC `ASR_MAX(`ASR_CEIL(`ASR_T_RC_NS), `ASR_CEIL(`ASR_T_AA_NS))
`define ASR_HZ_CYC `ASR_CEIL(`ASR_T_HZ_NS)
`define ASR_SD_CYC `ASR_CEIL(`ASR_T_SD_NS)
`define ASR_WE_CYC `ASR_MAX(`ASR_CEIL(`ASR_T_PWE_NS), \
   `ASR_CEIL(`ASR_T_SD_NS + `ASR_T_HZWE_NS))
`define ASR_WC_CYC `ASR_CEIL(`ASR_T_WC_NS)
`define ASR_WR_ADDR_CYC 1
`define ASR_WR_HOLD_CYC 1

`endif

// >>> hdl/asr_pkg.sv
// Types for the asynchronous byte memory host controller
package asr_pkg;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_RD_ACC,
      ST_RD_TURN,
      ST_WR_ADDR,
      ST_WR_PULSE,
      ST_WR_HOLD
   } asr_state_t;

endpackage
